// >>> rtl/burst_level_ctrl.sv
// burst-mode level select, blanking and burst control with apb registers
//
// Overview of operation
// - encode feedback level as one, two, three
// - entry threshold follows stored level
// - reduced burst current limit follows stored level
// - reference-good low keeps detection latch cleared
// - latch clear and off: current source on
// - at turn-on sample level, set latch
// - latched level ignores later feedback changes
// - short timer then resistor reconnects, source off
// - blanking counter zero normally, counts below threshold
// - enter burst when count limit reached below
// - on entry set flag, bias off
// - pick compensation curve by on-time boundary
// - burst uses compensated reduced current limit
// - burst bias resumes upper, stops lower
// - exit burst above exit threshold
`timescale 1ns/10ps
`include "burst_params.svh"
module burst_level_ctrl #(
    parameter int BLANK_CYCLES = `BLANK_CYCLES,
    parameter int SEL_CYCLES = `SEL_CYCLES,
    parameter int CURVE_CYCLES = `CURVE_CYCLES
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ref_good,
    input wire logic supply_on,
    input wire logic fb_above_ref_low,
    input wire logic fb_above_ref_high,
    input wire logic [2:0] fb_below_entry,
    input wire logic fb_above_upper,
    input wire logic fb_above_lower,
    input wire logic fb_above_exit,
    input wire logic gate_on,
    output burst_pkg::level_t level_code,
    output burst_pkg::onehot_t entry_thr_sel,
    output burst_pkg::onehot_t limit_sel,
    output logic sel_current_en,
    output logic sel_resistor_connect,
    output logic burst_flag,
    output logic bias_en,
    output logic burst_limit_active,
    output logic curve_long,
    output logic irq
);
    import burst_pkg::*;

    localparam int BW = $clog2(BLANK_CYCLES + 1);
    localparam int TW = $clog2(SEL_CYCLES + 1);
    localparam int SEL_WAIT = SEL_CYCLES + 1;

    generate
        if (BLANK_CYCLES < 2 || SEL_CYCLES < 1 || CURVE_CYCLES < 1
            || CURVE_CYCLES > 254) begin : g_chk
            $error("burst_level_ctrl: unsupported timing parameters");
        end
    endgenerate

    // ****************************************************************
    // decoding
    // ****************************************************************
    function automatic onehot_t lvl_onehot(input level_t lv);
        case (lv)
            2'h1: lvl_onehot = 3'h1;
            2'h2: lvl_onehot = 3'h2;
            2'h3: lvl_onehot = 3'h4;
            default: lvl_onehot = 3'h1;
        endcase
    endfunction

    // ****************************************************************
    // pin synchronisation
    // ****************************************************************
    sync_if #(.W(11)) pins ();
    assign pins.raw = {gate_on, fb_above_exit, fb_above_lower,
                       fb_above_upper, fb_below_entry, fb_above_ref_high,
                       fb_above_ref_low, supply_on, ref_good};
    pin_sync #(.W(11)) u_sync (
        .clk_sys(clk_sys),
        .rst(rst),
        .pins(pins)
    );

    logic ref_good_s;
    logic dev_on;
    logic ref_low_s;
    logic ref_high_s;
    logic [2:0] below_s;
    logic upper_s;
    logic lower_s;
    logic exit_s;
    logic gate_s;
    assign ref_good_s = pins.clean[0];
    assign dev_on = pins.clean[1];
    assign ref_low_s = pins.clean[2];
    assign ref_high_s = pins.clean[3];
    assign below_s = pins.clean[6:4];
    assign upper_s = pins.clean[7];
    assign lower_s = pins.clean[8];
    assign exit_s = pins.clean[9];
    assign gate_s = pins.clean[10];

    // ****************************************************************
    // level detection
    // ****************************************************************
    level_t level_in;
    level_t level_q;
    logic latch_q;
    logic on_prev_q;
    logic on_rise;
    logic [TW-1:0] sel_tmr_q;
    logic sel_current_en_q;
    logic ev_latch;

    assign level_in = ref_high_s ? 2'h3 : (ref_low_s ? 2'h2 : 2'h1);
    assign on_rise = dev_on && !on_prev_q;
    assign ev_latch = on_rise && ref_good_s && !latch_q;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            on_prev_q <= 1'b0;
        end else begin
            on_prev_q <= dev_on;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            latch_q <= 1'b0;
            level_q <= 2'h1;
        end else if (!ref_good_s) begin
            latch_q <= 1'b0;
        end else if (ev_latch) begin
            latch_q <= 1'b1;
            level_q <= level_in;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sel_current_en_q <= 1'b1;
            sel_tmr_q <= '0;
        end else if (on_rise) begin
            sel_tmr_q <= TW'(SEL_CYCLES);
        end else if (sel_tmr_q != '0) begin
            sel_tmr_q <= sel_tmr_q - 1'b1;
            if (sel_tmr_q == TW'(1)) begin
                sel_current_en_q <= 1'b0;
            end
        end else if (!latch_q && !dev_on) begin
            sel_current_en_q <= 1'b1;
        end
    end

    // ****************************************************************
    // burst control
    // ****************************************************************
    burst_state_e state_q;
    logic [BW-1:0] blank_cnt_q;
    logic fb_below;
    logic burst_allow;
    logic blank_done;
    logic flag_q;
    logic ev_entry;
    logic ev_exit;
    logic [31:0] ctrl_q;

    assign fb_below = |(below_s & lvl_onehot(level_q));
    assign burst_allow = ctrl_q[`CTRL_BURST_EN] && latch_q && dev_on;
    assign blank_done = blank_cnt_q == BW'(BLANK_CYCLES - 1);
    assign ev_entry = state_q == ST_BLANK && fb_below && blank_done
                      && burst_allow;
    assign ev_exit = (state_q == ST_BURST_IDLE || state_q == ST_BURST_RUN)
                     && (exit_s || !burst_allow);

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_q <= ST_NORMAL;
        end else begin
            case (state_q)
                ST_NORMAL: begin
                    if (burst_allow && fb_below) begin
                        state_q <= ST_BLANK;
                    end
                end
                ST_BLANK: begin
                    if (!fb_below || !burst_allow) begin
                        state_q <= ST_NORMAL;
                    end else if (blank_done) begin
                        state_q <= ST_BURST_IDLE;
                    end
                end
                ST_BURST_IDLE: begin
                    if (ev_exit) begin
                        state_q <= ST_NORMAL;
                    end else if (upper_s) begin
                        state_q <= ST_BURST_RUN;
                    end
                end
                ST_BURST_RUN: begin
                    if (ev_exit) begin
                        state_q <= ST_NORMAL;
                    end else if (!lower_s) begin
                        state_q <= ST_BURST_IDLE;
                    end
                end
                default: state_q <= ST_NORMAL;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            blank_cnt_q <= '0;
        end else if (state_q == ST_BLANK && fb_below && burst_allow
                     && !blank_done) begin
            blank_cnt_q <= blank_cnt_q + 1'b1;
        end else begin
            blank_cnt_q <= '0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            flag_q <= 1'b0;
        end else if (ev_entry) begin
            flag_q <= 1'b1;
        end else if (ev_exit) begin
            flag_q <= 1'b0;
        end
    end

    // ****************************************************************
    // compensation curve
    // ****************************************************************
    logic [7:0] on_cnt_q;
    logic gate_prev_q;
    logic curve_q;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            on_cnt_q <= 8'h00;
            gate_prev_q <= 1'b0;
            curve_q <= 1'b0;
        end else begin
            gate_prev_q <= gate_s;
            if (gate_s && on_cnt_q != 8'hFF) begin
                on_cnt_q <= on_cnt_q + 8'h01;
            end else if (!gate_s) begin
                on_cnt_q <= 8'h00;
            end
            if (gate_prev_q && !gate_s) begin
                curve_q <= on_cnt_q > 8'(CURVE_CYCLES);
            end
        end
    end

    // ****************************************************************
    // registers and interrupts
    // ****************************************************************
    logic [`EV_WIDTH-1:0] int_st_q;
    logic [`EV_WIDTH-1:0] int_mask_q;
    logic [`EV_WIDTH-1:0] ev_vec;
    logic [31:0] status_w;
    logic [31:0] prdata_q;
    logic pslverr_q;
    logic wr_en;
    logic setup;
    logic mapped;

    assign setup = psel && !penable;
    assign wr_en = psel && penable && pwrite;
    assign mapped = paddr == `REG_CTRL || paddr == `REG_STATUS
                    || paddr == `REG_INT_STATUS || paddr == `REG_INT_MASK;
    assign ev_vec = {ev_exit, ev_entry, ev_latch};

    always_comb begin
        status_w = 32'h0000_0000;
        status_w[`ST_LEVEL_LSB +: 2] = latch_q ? level_q : 2'h0;
        status_w[`ST_LATCH] = latch_q;
        status_w[`ST_STATE_LSB +: 2] = state_q;
        status_w[`ST_FLAG] = flag_q;
        status_w[`ST_BIAS] = bias_en;
        status_w[`ST_CURVE] = curve_q;
        status_w[`ST_SEL_CUR] = sel_current_en_q;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ctrl_q <= `CTRL_RST;
            int_mask_q <= `MASK_RST;
        end else if (wr_en && paddr == `REG_CTRL) begin
            ctrl_q <= {31'h0000_0000, pwdata[`CTRL_BURST_EN]};
        end else if (wr_en && paddr == `REG_INT_MASK) begin
            int_mask_q <= pwdata[`EV_WIDTH-1:0];
        end
    end

    // set wins over a write-one clear in the same cycle
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            int_st_q <= '0;
        end else if (wr_en && paddr == `REG_INT_STATUS) begin
            int_st_q <= (int_st_q & ~pwdata[`EV_WIDTH-1:0]) | ev_vec;
        end else begin
            int_st_q <= int_st_q | ev_vec;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            prdata_q <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else if (setup) begin
            pslverr_q <= !mapped;
            case (paddr)
                `REG_CTRL: prdata_q <= ctrl_q;
                `REG_STATUS: prdata_q <= status_w;
                `REG_INT_STATUS: prdata_q <= {29'h0000_0000, int_st_q};
                `REG_INT_MASK: prdata_q <= {29'h0000_0000, int_mask_q};
                default: prdata_q <= 32'h0000_0000;
            endcase
        end
    end

    assign prdata = prdata_q;
    assign pslverr = pslverr_q && psel && penable;
    assign pready = 1'b1;
    assign irq = |(int_st_q & int_mask_q);

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign level_code = level_q;
    assign entry_thr_sel = lvl_onehot(level_q);
    assign limit_sel = lvl_onehot(level_q);
    assign sel_current_en = sel_current_en_q;
    assign sel_resistor_connect = !sel_current_en_q;
    assign burst_flag = flag_q;
    assign bias_en = state_q != ST_BURST_IDLE;
    assign burst_limit_active = flag_q;
    assign curve_long = curve_q;

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    a_latch_refgood: assert property (!ref_good_s |=> !latch_q)
        else $error("latch not cleared while reference low");
    a_level_sample: assert property (ev_latch |=> latch_q
        && level_q == $past(level_in) && entry_thr_sel == lvl_onehot(level_q))
        else $error("level not sampled at turn-on");
    a_level_hold: assert property (
        latch_q && ref_good_s && !ev_latch |=> $stable(level_q))
        else $error("latched level changed");
    a_sel_source: assert property (
        !latch_q && !dev_on && sel_tmr_q == '0
        |=> sel_current_en && !sel_resistor_connect)
        else $error("selection source not enabled");
    a_sel_timer: assert property (on_rise && !rst
        |-> ##[1:SEL_WAIT] sel_resistor_connect)
        else $error("resistor not reconnected after timer");
    a_blank_zero: assert property (state_q == ST_NORMAL
        |-> blank_cnt_q == '0)
        else $error("blanking counter not zero in normal");
    a_early_rise: assert property (
        state_q == ST_BLANK && !fb_below
        |=> state_q == ST_NORMAL && blank_cnt_q == '0)
        else $error("counter not cleared on early rise");
    a_burst_entry: assert property ($rose(flag_q)
        |-> $past(blank_done) && $past(fb_below) && !bias_en)
        else $error("burst entered without full blanking");
    a_burst_exit: assert property (flag_q && exit_s
        |=> !flag_q && state_q == ST_NORMAL)
        else $error("burst not left above exit threshold");
    a_bias_resume: assert property (
        state_q == ST_BURST_IDLE && upper_s && !ev_exit |=> bias_en)
        else $error("bias not resumed above upper level");

    c_latch_set: cover property (ev_latch ##1 latch_q);
    c_burst_entry: cover property (ev_entry);
    c_burst_cycle: cover property (state_q == ST_BURST_RUN
        ##1 state_q == ST_BURST_IDLE);
    c_burst_exit: cover property (ev_exit && exit_s);
endmodule // burst_level_ctrl

// >>> inc/burst_params.svh
// constants for the burst-mode level control block
`ifndef BURST_PARAMS_SVH
`define BURST_PARAMS_SVH

// ********************************************************************
// timing
// ********************************************************************
`define CLK_HZ 20000000
`define BLANK_TIME_MS 20
`define BLANK_CYCLES (`BLANK_TIME_MS * `CLK_HZ / 1000)
`define SEL_TIME_US 2
`define SEL_CYCLES ((`SEL_TIME_US * `CLK_HZ + 999999) / 1000000)
`define CURVE_TIME_US 4
`define CURVE_CYCLES ((`CURVE_TIME_US * `CLK_HZ + 999999) / 1000000)

// ********************************************************************
// register offsets
// ********************************************************************
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_INT_STATUS 8'h08
`define REG_INT_MASK 8'h0C

// ********************************************************************
// field positions and reset values
// ********************************************************************
`define CTRL_BURST_EN 0
`define ST_LEVEL_LSB 0
`define ST_LATCH 2
`define ST_STATE_LSB 3
`define ST_FLAG 5
`define ST_BIAS 6
`define ST_CURVE 7
`define ST_SEL_CUR 8
`define EV_LATCH 0
`define EV_ENTRY 1
`define EV_EXIT 2
`define EV_WIDTH 3
`define CTRL_RST 32'h0000_0001
`define MASK_RST 3'h0

`endif

// >>> inc/burst_pkg.sv
// types shared by the burst-mode level control block
package burst_pkg;
    typedef enum logic [1:0] {
        ST_NORMAL = 2'b00,
        ST_BLANK = 2'b01,
        ST_BURST_IDLE = 2'b10,
        ST_BURST_RUN = 2'b11
    } burst_state_e;
    typedef logic [1:0] level_t;
    typedef logic [2:0] onehot_t;
endpackage

// >>> inc/sync_if.sv
// carrier between the pin synchroniser and the control logic
`timescale 1ns/10ps
interface sync_if #(parameter int W = 11);
    logic [W-1:0] raw;
    logic [W-1:0] clean;
    modport filt (input raw, output clean);
    modport user (output raw, input clean);
endinterface

// >>> rtl/pin_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
module pin_sync #(parameter int W = 11) (
    input wire logic clk_sys,
    input wire logic rst,
    sync_if.filt pins
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    wire [W-1:0] out_w;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            s1_q <= pins.raw;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // a bit changes only once stages two and three agree
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            logic out_q;
            always_ff @(posedge clk_sys) begin
                if (rst) begin
                    out_q <= 1'b0;
                end else if (s2_q[i] == s3_q[i]) begin
                    out_q <= s3_q[i];
                end
            end
            assign out_w[i] = out_q;
        end
    endgenerate

    assign pins.clean = out_w;
endmodule // pin_sync

// >>> testbench/fb_network_model.sv
// model of the feedback network and supply comparators at the pins
`timescale 1ns/10ps
module fb_network_model (
    input wire logic clk_sys,
    input wire logic [15:0] fb_mv,
    input wire logic [15:0] vcc_mv,
    output logic ref_good,
    output logic supply_on,
    output logic fb_above_ref_low,
    output logic fb_above_ref_high,
    output logic [2:0] fb_below_entry,
    output logic fb_above_upper,
    output logic fb_above_lower,
    output logic fb_above_exit
);
    // ****************************************************************
    // comparator outputs, changed just after each rising edge
    // ****************************************************************
    initial begin
        ref_good = 1'b0;
        supply_on = 1'b0;
        fb_above_ref_low = 1'b0;
        fb_above_ref_high = 1'b0;
        fb_below_entry = 3'h0;
        fb_above_upper = 1'b0;
        fb_above_lower = 1'b0;
        fb_above_exit = 1'b0;
    end
    always @(posedge clk_sys) begin
        // reference good from 8 V, turn-on at 17 V
        ref_good <= vcc_mv >= 16'h1F40;
        supply_on <= vcc_mv >= 16'h4268;
        // level references 1.8 V and 4.0 V
        fb_above_ref_low <= fb_mv > 16'h0708;
        fb_above_ref_high <= fb_mv > 16'h0FA0;
        // entry thresholds 1.29 V, 1.61 V, 1.84 V
        fb_below_entry[0] <= fb_mv < 16'h050A;
        fb_below_entry[1] <= fb_mv < 16'h064A;
        fb_below_entry[2] <= fb_mv < 16'h0730;
        // burst levels 3.5 V and 3.2 V, exit 4.0 V
        fb_above_upper <= fb_mv > 16'h0DAC;
        fb_above_lower <= fb_mv > 16'h0C80;
        fb_above_exit <= fb_mv > 16'h0FA0;
    end
endmodule // fb_network_model

// >>> testbench/burst_level_ctrl_tb.sv
// self-checking bench for the burst-mode level control block
`timescale 1ns/10ps
module burst_level_ctrl_tb;
    import burst_pkg::*;
    localparam int BLANK = 20;
    localparam int SEL = 8;
    localparam int CURVE = 30;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic gate_on = 1'b0;
    logic [15:0] fb_mv = 16'h0000;
    logic [15:0] vcc_mv = 16'h0000;
    logic ref_good, supply_on, ref_lo, ref_hi, up, lo, ex;
    logic [2:0] below;
    level_t level_code;
    onehot_t entry_thr_sel;
    onehot_t limit_sel;
    logic sel_cur, sel_res, burst_flag, bias_en, lim_act, curve_long, irq;
    int n_errors = 0;
    int comparisons = 0;
    int seed = 76;
    int entry_mv[3] = '{1290, 1610, 1840};
    logic [31:0] rd;
    logic err;
    int lvl, cnt, t, xl, oh;

    always #25 clk_sys = ~clk_sys;

    fb_network_model i_fb_network_model (.clk_sys(clk_sys), .fb_mv(fb_mv),
        .vcc_mv(vcc_mv), .ref_good(ref_good), .supply_on(supply_on),
        .fb_above_ref_low(ref_lo), .fb_above_ref_high(ref_hi),
        .fb_below_entry(below), .fb_above_upper(up), .fb_above_lower(lo),
        .fb_above_exit(ex));

    burst_level_ctrl #(.BLANK_CYCLES(BLANK), .SEL_CYCLES(SEL),
        .CURVE_CYCLES(CURVE)) i_burst_level_ctrl (.clk_sys(clk_sys),
        .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ref_good(ref_good), .supply_on(supply_on),
        .fb_above_ref_low(ref_lo), .fb_above_ref_high(ref_hi),
        .fb_below_entry(below), .fb_above_upper(up), .fb_above_lower(lo),
        .fb_above_exit(ex), .gate_on(gate_on), .level_code(level_code),
        .entry_thr_sel(entry_thr_sel), .limit_sel(limit_sel),
        .sel_current_en(sel_cur), .sel_resistor_connect(sel_res),
        .burst_flag(burst_flag), .bias_en(bias_en),
        .burst_limit_active(lim_act), .curve_long(curve_long), .irq(irq));

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic int rnd(int n);
        return ($random(seed) & 32'h7FFF_FFFF) % n;
    endfunction

    // reference level pick from the feedback voltage in millivolts
    function automatic int exp_level(int mv);
        return mv > 4000 ? 3 : mv > 1800 ? 2 : 1;
    endfunction

    task chk(input string what, input logic [31:0] exp,
             input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task chk_span(input string what, input int lo_n, input int hi_n,
                  input int got);
        comparisons++;
        if (got < lo_n || got > hi_n) begin
            n_errors++;
            $display("unexpected %s: expected %0d..%0d, seen %0d", what,
                     lo_n, hi_n, got);
        end
    endtask

    task tally_and_finish;
        $display("errors %0d, comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task settle(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        repeat (16) @(posedge clk_sys);
        rst <= 1'b0;
        settle(1);
        chk("level_code", 1, level_code);
        chk("sel_current_en", 1, sel_cur);
        chk("sel_resistor_connect", 0, sel_res);
        chk("bias_en", 1, bias_en);
        apb(1'b0, 8'h00, 32'h0000_0000);
        chk("ctrl", 32'h0000_0001, rd);
        apb(1'b0, 8'h04, 32'h0000_0000);
        chk("status latch", 0, rd[2:0]);
        apb(1'b0, 8'h0C, 32'h0000_0000);
        chk("int_mask", 0, rd);
        apb(1'b0, 8'h10, 32'h0000_0000);
        chk("unmapped error", 1, err);
        chk("unmapped data", 0, rd);
        for (lvl = 1; lvl <= 3; lvl++) begin
            // level pick at turn-on and selection timer
            t = lvl == 1 ? 1300 + rnd(450) : lvl == 2 ? 1900 + rnd(2000)
                : 4100 + rnd(800);
            fb_mv <= 16'(t);
            vcc_mv <= 16'h2328;
            settle(10);
            chk("sel_current_en", 1, sel_cur);
            vcc_mv <= 16'h4650;
            cnt = 0;
            while (sel_res !== 1'b1 && cnt < 200) begin
                settle(1);
                cnt++;
            end
            xl = exp_level(t);
            oh = 1 << (xl - 1);
            chk_span("select timer", SEL + 2, SEL + 7, cnt);
            chk("sel_current_en", 0, sel_cur);
            chk("level_code", xl, level_code);
            chk("entry_thr_sel", oh, entry_thr_sel);
            chk("limit_sel", oh, limit_sel);
            chk("irq masked", 0, irq);
            fb_mv <= lvl == 3 ? 16'h09C4 : 16'h1194;
            settle(10);
            chk("level_code held", xl, level_code);
            apb(1'b0, 8'h04, 32'h0000_0000);
            chk("status", 4 | xl, rd[2:0]);
            // just above own threshold, then a short dip
            fb_mv <= 16'(entry_mv[lvl - 1] + 60);
            settle(3 * BLANK);
            chk("burst_flag", 0, burst_flag);
            fb_mv <= 16'(entry_mv[lvl - 1] - 150);
            settle(BLANK / 2);
            fb_mv <= 16'h09C4;
            settle(3 * BLANK);
            chk("burst_flag", 0, burst_flag);
            // no entry while burst is disabled
            apb(1'b1, 8'h00, 32'h0000_0000);
            fb_mv <= 16'(entry_mv[lvl - 1] - 150);
            settle(3 * BLANK);
            chk("burst_flag off", 0, burst_flag);
            // entry after blanking, counted from re-enable
            apb(1'b1, 8'h0C, 32'h0000_0006);
            apb(1'b1, 8'h00, 32'h0000_0001);
            cnt = 0;
            while (burst_flag !== 1'b1 && cnt < 200) begin
                settle(1);
                cnt++;
            end
            chk_span("blanking", BLANK + 1, BLANK + 8, cnt);
            settle(2);
            chk("bias_en", 0, bias_en);
            chk("burst_limit_active", 1, lim_act);
            chk("irq entry", 1, irq);
            fb_mv <= 16'h0E10;
            settle(10);
            chk("bias_en", 1, bias_en);
            fb_mv <= 16'h0CE4;
            settle(10);
            chk("bias_en", 1, bias_en);
            fb_mv <= 16'h0BB8;
            settle(10);
            chk("bias_en", 0, bias_en);
            fb_mv <= 16'h1068;
            settle(10);
            chk("burst_flag", 0, burst_flag);
            chk("burst_limit_active", 0, lim_act);
            apb(1'b0, 8'h08, 32'h0000_0000);
            chk("int_status", 7, rd[2:0]);
            apb(1'b1, 8'h08, 32'h0000_0007);
            settle(2);
            chk("irq cleared", 0, irq);
            // compensation curve by on-time
            t = CURVE - 15 + rnd(8);
            gate_on <= 1'b1;
            settle(t);
            gate_on <= 1'b0;
            settle(10);
            chk("curve_long", 0, curve_long);
            t = CURVE + 10 + rnd(8);
            gate_on <= 1'b1;
            settle(t);
            gate_on <= 1'b0;
            settle(10);
            chk("curve_long", 1, curve_long);
            // power down clears the latch
            vcc_mv <= 16'h1388;
            settle(10);
            apb(1'b0, 8'h04, 32'h0000_0000);
            chk("status latch", 0, rd[2:0]);
            chk("sel_current_en", 1, sel_cur);
            chk("sel_resistor_connect", 0, sel_res);
        end
        tally_and_finish;
    end

    // ****************************************************************
    // watchdog
    // ****************************************************************
    initial begin
        repeat (20000) @(posedge clk_sys);
        n_errors++;
        tally_and_finish;
    end
endmodule // burst_level_ctrl_tb
